/* test_tmi2c.sv */
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t: %s", $time, m); end end
module test_tmi2c;
  import tmi2c_pkg::*;
  localparam logic [6:0] DEV = DEV_ADDR_BASE;
  logic pclk = '0;
  logic presetn = '0;
  logic psel = '0;
  logic penable = '0;
  logic pwrite = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_start;
  logic conv_abort;
  logic conv_busy;
  logic conv_done;
  logic [7:0] local_temp = 8'h20;
  logic [7:0] remote_temp = 8'h20;
  logic open_diode = '0;
  logic [31:0] stat;
  logic [7:0] v;
  logic err;
  int failures = 0;
  int n_tests = 0;
  int n_starts;
  int cc;
  tmi2c_if link ();
  tmi2c_host u_tmi2c_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  tmi2c_dev #(.DEV_ADDR(DEV), .TIMEOUT_CYC(200)) u_tmi2c_dev (.pclk(pclk), .presetn(presetn), .link(link),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_busy(conv_busy), .conv_done(conv_done),
    .local_temp(local_temp), .remote_temp(remote_temp), .open_diode(open_diode));
  tmi2c_checker u_tmi2c_checker (.pclk(pclk), .presetn(presetn), .scl_oe(link.scl_oe),
    .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe), .alert_oe(link.alert_oe),
    .alert_out(link.alert_out), .scl(link.scl), .sda(link.sda));
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Converter stand-in: twenty cycles per conversion, abort drops it silently.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_busy <= '0;
      conv_done <= '0;
      cc <= 0;
      n_starts <= 0;
    end else begin
      conv_done <= '0;
      if (conv_abort) begin
        conv_busy <= '0;
      end else if (conv_start) begin
        conv_busy <= 1'h1;
        cc <= 20;
        n_starts <= n_starts + 1;
      end else if (conv_busy) begin
        cc <= cc - 1;
        if (cc == 1) begin
          conv_busy <= '0;
          conv_done <= 1'h1;
        end
      end
    end
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= '0;
    penable <= '0;
    @(posedge pclk);
  endtask
  task automatic xfer(input logic [6:0] a, input logic rw, input logic [1:0] n, input logic [7:0] b0, b1);
    logic [31:0] r;
    int k;
    apb(1'h1, H_CMD, {b1, b0, 6'h00, n, rw, a}, r);
    k = 0;
    do begin
      apb(1'h0, H_STAT, '0, r);
      k++;
    end while (r[0] !== 1'h0 && k < 800);
    stat = r;
    `CHK(r[0], 1'h0, "transfer hung")
  endtask
  task automatic rdreg(input logic [7:0] p, output logic [7:0] d);
    xfer(DEV, 1'h0, 2'h1, p, 8'h00);
    xfer(DEV, 1'h1, 2'h0, 8'h00, 8'h00);
    d = stat[15:8];
  endtask
  task automatic waitconv;
    int n0;
    int k;
    n0 = n_starts;
    k = 0;
    while (n_starts < n0 + 2 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    wcyc(3);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    rdreg(RD_CFG, v);
    `CHK(v, RST_CFG, "config reset value")
    rdreg(RD_LHI, v);
    `CHK(v, RST_HI, "high limit reset value")
    xfer(DEV, 1'h0, 2'h2, WR_LLO, 8'h12);
    rdreg(RD_LLO, v);
    `CHK(v, 8'h12, "limit write")
    xfer(DEV, 1'h1, 2'h0, 8'h00, 8'h00);
    `CHK(stat[15:8], 8'h12, "pointer not kept")
    rdreg(WR_LLO, v);
    `CHK(v, 8'h00, "write-only pointer read")
    rdreg(RD_LLO, v);
    `CHK(v, 8'h12, "pointer byte stored as data")
    apb(1'h0, 8'h08, '0, r);
    `CHK({err, r}, {1'h1, 32'h0}, "unmapped host offset")
    $display("registers test done");
  endtask
  task automatic t_addr;
    xfer(7'h4d, 1'h0, 2'h1, RD_CFG, 8'h00);
    `CHK(stat[1], 1'h1, "foreign address acknowledged")
    xfer(DEV, 1'h0, 2'h1, RD_CFG, 8'h00);
    `CHK(stat[1], 1'h0, "own address refused")
    $display("address test done");
  endtask
  task automatic t_alert;
    local_temp <= 8'h60;
    waitconv();
    `CHK(link.alert_n, 1'h0, "alarm not raised")
    xfer(ARA_ADDR, 1'h1, 2'h0, 8'h00, 8'h00);
    `CHK(stat[15:8], {DEV, 1'h1}, "alert response byte")
    `CHK(stat[2], 1'h1, "alert line not seen low")
    `CHK(link.alert_n, 1'h0, "alarm released with flags set")
    local_temp <= 8'h20;
    waitconv();
    rdreg(RD_STAT, v);
    `CHK(v & 8'h7c, 8'h40, "status flags")
    `CHK(link.alert_n, 1'h0, "alarm released by status read")
    xfer(ARA_ADDR, 1'h1, 2'h0, 8'h00, 8'h00);
    `CHK(link.alert_n, 1'h1, "alarm kept after response")
    `CHK(stat[2], 1'h0, "alert line still seen low")
    $display("alarm test done");
  endtask
  task automatic t_stby;
    int n0;
    xfer(DEV, 1'h0, 2'h2, WR_CFG, 8'h40);
    rdreg(RD_CFG, v);
    `CHK(v, 8'h40, "standby config")
    n0 = n_starts;
    wcyc(300);
    `CHK(n_starts, n0, "conversion in standby")
    xfer(DEV, 1'h0, 2'h2, WR_LHI, 8'h10);
    wcyc(4);
    `CHK(link.alert_n, 1'h0, "standby limit recheck")
    xfer(DEV, 1'h0, 2'h2, WR_ONESHOT, 8'haa);
    wcyc(40);
    `CHK(n_starts, n0 + 1, "one-shot count")
    open_diode <= 1'h1;
    xfer(DEV, 1'h0, 2'h2, WR_ONESHOT, 8'h00);
    wcyc(40);
    rdreg(RD_STAT, v);
    `CHK(v & 8'h04, 8'h04, "open diode flag")
    xfer(DEV, 1'h0, 2'h2, WR_CFG, 8'h60);
    `CHK(link.alert_n, 1'h1, "alarm pin active in second-limit mode")
    $display("standby test done");
  endtask
  initial begin
    wcyc(3);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_addr();
    t_alert();
    t_stby();
    conclude();
  end
  initial begin
    wcyc(90000);
    failures++;
    conclude();
  end
endmodule

/* tmi2c_checker.sv */
`timescale 1ns/1ps
module tmi2c_checker (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link signals.
  input wire logic scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic alert_oe,
  input wire logic alert_out,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [4:0] nrise;
  // Counts clock rises on the wire since the last start condition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      nrise <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        nrise <= '0;
      end else if (scl && !scl_q && nrise != 5'h1f) begin
        nrise <= nrise + 5'h01;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  od_drive_a: assert property (alert_oe |-> !alert_out)
    else $error("alarm line driven high");
  sda_hold_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("device data moved while clock high");
  scl_low_a: assert property ($rose(scl_oe) |-> scl_oe[*8] ##1 !scl_oe)
    else $error("clock low phase length wrong");
  scl_high_a: assert property ($fell(scl_oe) |-> (!scl_oe)[*8])
    else $error("clock high phase too short");
  start_gap_a: assert property ($rose(m_sda_oe) && scl |-> ##8 $rose(scl_oe))
    else $error("first clock not after start");
  stop_rel_a: assert property ($fell(m_sda_oe) && scl |-> !s_sda_oe)
    else $error("device holds data at stop");
  alert_rel_a: assert property ($fell(alert_oe) |-> !scl)
    else $error("alarm released outside clock low");
  addr_ack_a: assert property ($rose(s_sda_oe) && nrise < 5'h09 |-> nrise == 5'h08)
    else $error("address acknowledge in wrong slot");
endmodule

/* tmi2c_dev.sv */
`timescale 1ns/1ps
// What this block does
// - Answer own fixed address, or alert response read while alarm low.
// - Start opens; shift address then direction.
// - Matched address acknowledged before ninth clock.
// - Direction zero writes, one reads.
// - Nine clocks: eight data, receiver acknowledges.
// - Data changes only while clock low.
// - Master ends reads with not-acknowledge, stop.
// - First written byte loads the pointer.
// - Next written byte goes to pointed register.
// - Reads return pointed register; pointer persists.
// - Separate read and write pointer values.
// - Alarm low on limit or open diode.
// - Alarm output only sinks low.
// - Answer alert response address with own address.
// - Master repeats alert reads while line low.
// - Lost arbitration withdraws, alarm kept.
// - Alarm released after response if fault gone.
// - Standby halts and aborts conversions.
// - One-shot write converts once in standby.
// - Standby limit writes recompare stored values.
// - Open diode sampled at conversion start.
// - Optional bus timeout releases data line.
// - Flags stay until status read.
module tmi2c_dev #(
  parameter logic [6:0] DEV_ADDR = tmi2c_pkg::DEV_ADDR_BASE,
  parameter int TIMEOUT_CYC = tmi2c_pkg::TIMEOUT_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Two-wire link.
  tmi2c_if.dev link,
  // Converter.
  output logic conv_start,
  output logic conv_abort,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  input wire logic open_diode
);
  import tmi2c_pkg::*;

  localparam logic [21:0] TMO_LAST = 22'(TIMEOUT_CYC - 1);

  typedef struct packed {
    tmi2c_sst_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic ara;
    logic first;
    logic nak;
    logic [7:0] ptr;
    logic sda_oe;
    logic alert_oe;
    logic [7:0] cfg;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic [7:0] cons;
    logic [7:0] ltmp;
    logic [7:0] rtmp;
    logic [7:0] stat;
    logic [21:0] tmo;
    logic run;
    logic oneshot;
    logic chk;
    logic conv_start;
    logic conv_abort;
  } tmi2c_dev_t;

  tmi2c_dev_t q;
  tmi2c_dev_t n;
  logic s_scl;
  logic s_sda;
  logic scl_r;
  logic scl_f;
  logic start_c;
  logic stop_c;
  logic [7:0] rdata;

  tmi2c_sync u_scl (.pclk(pclk), .presetn(presetn), .d(link.scl), .q(s_scl));
  tmi2c_sync u_sda (.pclk(pclk), .presetn(presetn), .d(link.sda), .q(s_sda));

  assign scl_r = s_scl & ~q.scl_q;
  assign scl_f = ~s_scl & q.scl_q;
  assign start_c = s_scl & q.scl_q & q.sda_q & ~s_sda;
  assign stop_c = s_scl & q.scl_q & ~q.sda_q & s_sda;

  // Write-only pointer values read as zero.
  always_comb begin
    case (q.ptr)
      RD_LTEMP: rdata = q.ltmp;
      RD_RTEMP: rdata = q.rtmp;
      RD_STAT: rdata = {q.run, q.stat[6:0]};
      RD_CFG: rdata = q.cfg;
      RD_LHI: rdata = q.lhi;
      RD_LLO: rdata = q.llo;
      RD_RHI: rdata = q.rhi;
      RD_RLO: rdata = q.rlo;
      RW_CONS: rdata = q.cons;
      default: rdata = 8'h00;
    endcase
  end

  always_comb begin
    logic stat_clr;
    logic ara_done;
    logic lim_wr;
    logic [7:0] setb;
    stat_clr = 1'b0;
    ara_done = 1'b0;
    lim_wr = 1'b0;
    setb = 8'h00;
    n = q;
    n.scl_q = s_scl;
    n.sda_q = s_sda;
    n.conv_start = 1'b0;
    n.conv_abort = 1'b0;
    n.chk = 1'b0;
    if (scl_r || scl_f || (s_sda != q.sda_q) || q.st == S_IDLE) begin
      n.tmo = 22'h000000;
    end else begin
      n.tmo = q.tmo + 22'h000001;
    end
    case (q.st)
      S_ADDR: begin
        if (scl_r) begin
          n.sh = {q.sh[6:0], s_sda};
          n.cnt = q.cnt + 4'h1;
        end else if (scl_f && q.cnt == 4'h8) begin
          n.rw = q.sh[0];
          n.ara = q.sh[7:1] == ARA_ADDR;
          if (q.sh[7:1] == DEV_ADDR || (q.sh[7:1] == ARA_ADDR && q.sh[0] && q.alert_oe)) begin
            n.st = S_AACK;
            n.sda_oe = 1'b1;
          end else begin
            n.st = S_IDLE;
          end
        end
      end
      S_AACK, S_WACK: begin
        if (scl_f) begin
          n.cnt = 4'h0;
          n.sda_oe = 1'b0;
          if (q.st == S_AACK && q.rw) begin
            n.st = S_RD;
            n.sh = q.ara ? {DEV_ADDR, 1'b1} : rdata;
            n.sda_oe = q.ara ? ~DEV_ADDR[6] : ~rdata[7];
            n.cnt = 4'h1;
          end else begin
            n.st = S_WR;
          end
        end
      end
      S_WR: begin
        if (scl_r) begin
          n.sh = {q.sh[6:0], s_sda};
          n.cnt = q.cnt + 4'h1;
        end else if (scl_f && q.cnt == 4'h8) begin
          n.st = S_WACK;
          n.sda_oe = 1'b1;
          n.first = 1'b0;
          if (q.first) begin
            n.ptr = q.sh;
          end else begin
            case (q.ptr)
              WR_CFG: n.cfg = q.sh;
              WR_LHI: n.lhi = q.sh;
              WR_LLO: n.llo = q.sh;
              WR_RHI: n.rhi = q.sh;
              WR_RLO: n.rlo = q.sh;
              WR_ONESHOT: n.oneshot = q.cfg[CFG_STBY];
              RW_CONS: n.cons = q.sh;
              default: ;
            endcase
            lim_wr = q.ptr inside {WR_LHI, WR_LLO, WR_RHI, WR_RLO};
          end
        end
      end
      S_RD: begin
        if (scl_r && !q.sda_oe && !s_sda) begin
          n.st = S_IDLE;
        end else if (scl_f) begin
          if (q.cnt == 4'h8) begin
            n.st = S_RACK;
            n.sda_oe = 1'b0;
            ara_done = q.ara;
            stat_clr = !q.ara && q.ptr == RD_STAT;
          end else begin
            n.sh = {q.sh[6:0], 1'b0};
            n.sda_oe = ~q.sh[6];
            n.cnt = q.cnt + 4'h1;
          end
        end
      end
      S_RACK: begin
        if (scl_r) begin
          n.nak = s_sda;
        end else if (scl_f) begin
          if (q.nak) begin
            n.st = S_IDLE;
          end else begin
            n.st = S_RD;
            n.sh = q.ara ? {DEV_ADDR, 1'b1} : rdata;
            n.sda_oe = q.ara ? ~DEV_ADDR[6] : ~rdata[7];
            n.cnt = 4'h1;
          end
        end
      end
      default: ;
    endcase
    if (start_c) begin
      n.st = S_ADDR;
      n.cnt = 4'h0;
      n.first = 1'b1;
      n.sda_oe = 1'b0;
    end else if (stop_c || (q.cons[CONS_TMO] && q.tmo == TMO_LAST)) begin
      n.st = S_IDLE;
      n.sda_oe = 1'b0;
    end
    // Conversion sequencing toward the converter.
    if (q.cfg[CFG_STBY] && q.run && !q.oneshot) begin
      n.run = 1'b0;
      n.conv_abort = 1'b1;
    end else if (q.run && conv_done) begin
      n.run = 1'b0;
      n.oneshot = 1'b0;
      n.ltmp = local_temp;
      n.rtmp = remote_temp;
      setb = tmi2c_lim(local_temp, remote_temp, q.lhi, q.llo, q.rhi, q.rlo);
    end else if (!q.run && !conv_busy && (!q.cfg[CFG_STBY] || q.oneshot)) begin
      n.run = 1'b1;
      n.conv_start = 1'b1;
      setb[ST_OPEN] = open_diode;
    end
    n.chk = lim_wr && q.cfg[CFG_STBY];
    if (q.chk) begin
      setb = setb | tmi2c_lim(q.ltmp, q.rtmp, q.lhi, q.llo, q.rhi, q.rlo);
    end
    n.stat = (stat_clr ? 8'h00 : q.stat) | setb;
    if (q.cfg[CFG_THERM2]) begin
      n.alert_oe = 1'b0;
    end else if (|setb[6:2]) begin
      n.alert_oe = 1'b1;
    end else if (ara_done && ~|n.stat[6:2]) begin
      n.alert_oe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: S_IDLE, scl_q: 1'b1, sda_q: 1'b1, cfg: RST_CFG, lhi: RST_HI, llo: RST_LO,
        rhi: RST_HI, rlo: RST_LO, cons: RST_CONS, default: '0};
    end else begin
      q <= n;
    end
  end

  assign link.s_sda_oe = q.sda_oe;
  assign link.s_sda_out = 1'b0;
  assign link.alert_oe = q.alert_oe;
  assign link.alert_out = 1'b0;
  assign conv_start = q.conv_start;
  assign conv_abort = q.conv_abort;
endmodule

/* tmi2c_host.sv */
`timescale 1ns/1ps
module tmi2c_host #(
  parameter int HALF = tmi2c_pkg::HALF_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Two-wire link.
  tmi2c_if.host link
);
  import tmi2c_pkg::*;

  localparam logic [7:0] T_HALF = 8'(HALF - 1);
  localparam logic [7:0] T_QTR = 8'(HALF / 2);

  typedef struct packed {
    tmi2c_hst_t st;
    logic [1:0] ph;
    logic [7:0] tmr;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [6:0] addr;
    logic rw;
    logic [1:0] nwr;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] sh;
    logic [7:0] rx;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmi2c_host_t;

  tmi2c_host_t q;
  tmi2c_host_t n;
  logic s_sda;
  logic s_alert_n;

  tmi2c_sync u_sda (.pclk(pclk), .presetn(presetn), .d(link.sda), .q(s_sda));
  tmi2c_sync u_alert (.pclk(pclk), .presetn(presetn), .d(link.alert_n), .q(s_alert_n));

  always_comb begin
    logic rd_byte;
    logic last;
    rd_byte = q.rw && q.byten != 2'h0;
    last = q.byten == (q.rw ? 2'h1 : q.nwr);
    n = q;
    n.tmr = (q.tmr == 8'h00) ? T_HALF : q.tmr - 8'h01;
    // One wait state: data and error are presented with pready in the second access cycle.
    n.pready = psel && penable && !q.pready;
    n.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      n.pslverr = !(paddr == H_CMD || paddr == H_STAT);
      n.prdata = (paddr == H_STAT) ? {16'h0000, q.rx, 5'h00, ~s_alert_n, q.nack, q.st != H_IDLE} : 32'h00000000;
    end
    case (q.st)
      H_IDLE: begin
        if (psel && penable && pwrite && q.pready && paddr == H_CMD) begin
          n.st = H_START;
          n.addr = pwdata[6:0];
          n.rw = pwdata[CMD_RW];
          n.nwr = pwdata[CMD_NWR+1:CMD_NWR];
          n.d0 = pwdata[CMD_D0+7:CMD_D0];
          n.d1 = pwdata[CMD_D1+7:CMD_D1];
          n.nack = 1'b0;
          n.sda_oe = 1'b1;
          n.tmr = T_HALF;
        end
      end
      H_START: begin
        if (q.tmr == 8'h00) begin
          n.st = H_BIT;
          n.ph = 2'h0;
          n.scl_oe = 1'b1;
          n.bitn = 4'h0;
          n.byten = 2'h0;
          n.sh = {q.addr, q.rw};
        end
      end
      H_BIT: begin
        if (q.ph == 2'h0 && q.tmr == T_QTR) begin
          n.sda_oe = (q.bitn != 4'h8 && !rd_byte) ? ~q.sh[7] : 1'b0;
        end else if (q.tmr == 8'h00 && q.ph == 2'h0) begin
          n.scl_oe = 1'b0;
          n.ph = 2'h1;
        end else if (q.tmr == 8'h00) begin
          n.scl_oe = 1'b1;
          n.ph = 2'h0;
          if (q.bitn != 4'h8) begin
            n.rx = rd_byte ? {q.rx[6:0], s_sda} : q.rx;
            n.sh = {q.sh[6:0], 1'b0};
            n.bitn = q.bitn + 4'h1;
          end else if ((!rd_byte && s_sda) || last) begin
            n.nack = !rd_byte && s_sda;
            n.st = H_STOP;
          end else begin
            n.bitn = 4'h0;
            n.byten = q.byten + 2'h1;
            n.sh = (q.byten == 2'h0) ? q.d0 : q.d1;
          end
        end
      end
      H_STOP: begin
        if (q.ph == 2'h0 && q.tmr == T_QTR) begin
          n.sda_oe = 1'b1;
        end else if (q.tmr == 8'h00) begin
          n.ph = q.ph + 2'h1;
          n.scl_oe = 1'b0;
          if (q.ph == 2'h1) begin
            n.sda_oe = 1'b0;
          end else if (q.ph == 2'h2) begin
            n.st = H_IDLE;
          end
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: H_IDLE, default: '0};
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link.scl_oe = q.scl_oe;
  assign link.scl_out = 1'b0;
  assign link.m_sda_oe = q.sda_oe;
  assign link.m_sda_out = 1'b0;
endmodule

/* tmi2c_if.sv */
`timescale 1ns/1ps
interface tmi2c_if;
  logic scl_oe;
  logic scl_out;
  logic m_sda_oe;
  logic m_sda_out;
  logic s_sda_oe;
  logic s_sda_out;
  logic alert_oe;
  logic alert_out;
  logic scl;
  logic sda;
  logic alert_n;
  // Pull-ups make every line wired-and of its drivers.
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));
  assign alert_n = ~(alert_oe & ~alert_out);
  modport dev(input scl, input sda, input alert_n, output s_sda_oe, output s_sda_out,
    output alert_oe, output alert_out);
  modport host(input scl, input sda, input alert_n, output scl_oe, output scl_out,
    output m_sda_oe, output m_sda_out);
endinterface

/* tmi2c_pkg.sv */
package tmi2c_pkg;
  // Bus addresses.
  localparam logic [6:0] DEV_ADDR_BASE = 7'h4c;
  localparam logic [6:0] DEV_ADDR_ALT = 7'h4d;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  // Pointer values for reads.
  localparam logic [7:0] RD_LTEMP = 8'h00;
  localparam logic [7:0] RD_RTEMP = 8'h01;
  localparam logic [7:0] RD_STAT = 8'h02;
  localparam logic [7:0] RD_CFG = 8'h03;
  localparam logic [7:0] RD_LHI = 8'h05;
  localparam logic [7:0] RD_LLO = 8'h06;
  localparam logic [7:0] RD_RHI = 8'h07;
  localparam logic [7:0] RD_RLO = 8'h08;
  // Pointer values for writes.
  localparam logic [7:0] WR_CFG = 8'h09;
  localparam logic [7:0] WR_LHI = 8'h0b;
  localparam logic [7:0] WR_LLO = 8'h0c;
  localparam logic [7:0] WR_RHI = 8'h0d;
  localparam logic [7:0] WR_RLO = 8'h0e;
  localparam logic [7:0] WR_ONESHOT = 8'h0f;
  localparam logic [7:0] RW_CONS = 8'h22;
  // Field positions.
  localparam int CFG_STBY = 6;
  localparam int CFG_THERM2 = 5;
  localparam int CONS_TMO = 7;
  localparam int ST_BUSY = 7;
  localparam int ST_OPEN = 2;
  // Values after reset.
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_HI = 8'h55;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [7:0] RST_CONS = 8'h01;
  // Timing.
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int LINK_PERIOD_NS = 160;
  localparam int HALF_CYC = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
  // Host register offsets and fields.
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam int CMD_RW = 7;
  localparam int CMD_NWR = 8;
  localparam int CMD_D0 = 16;
  localparam int CMD_D1 = 24;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK} tmi2c_sst_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tmi2c_hst_t;

  // Out-of-limit flags in status bit positions 6 to 3.
  function automatic logic [7:0] tmi2c_lim(input logic [7:0] lt, input logic [7:0] rt,
    input logic [7:0] lhi, input logic [7:0] llo, input logic [7:0] rhi, input logic [7:0] rlo);
    tmi2c_lim = 8'h00;
    tmi2c_lim[6] = $signed(lt) > $signed(lhi);
    tmi2c_lim[5] = $signed(lt) < $signed(llo);
    tmi2c_lim[4] = $signed(rt) > $signed(rhi);
    tmi2c_lim[3] = $signed(rt) < $signed(rlo);
  endfunction
endpackage

/* tmi2c_sync.sv */
`timescale 1ns/1ps
module tmi2c_sync (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous level in, filtered level out.
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic q;
  } tmi2c_sync_t;
  tmi2c_sync_t s;
  tmi2c_sync_t next_s;

  // The output follows only once the second and third stages agree.
  always_comb begin
    next_s = s;
    next_s.f1 = d;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    if (s.f2 == s.f3) begin
      next_s.q = s.f3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{f1: 1'b1, f2: 1'b1, f3: 1'b1, q: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule
